// *** hdl/lpr_pkg.sv ***
// Package: constants, codes and types for the light/proximity result readout
package lpr_pkg;

  // Fixed 7-bit bus address of the slave
  localparam logic [6:0] I2C_ADDR     = 7'h44;

  // Register offsets
  localparam logic [7:0] REG_CMD1     = 8'h00;
  localparam logic [7:0] REG_CMD2     = 8'h01;
  localparam logic [7:0] REG_RES_LO   = 8'h02;
  localparam logic [7:0] REG_RES_HI   = 8'h03;

  // Reset values
  localparam logic [2:0]  MODE_RESET  = 3'h0;
  localparam logic [7:0]  CMD2_RESET  = 8'h00;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  // Field positions in the first command register
  localparam int MODE_MSB = 7;
  localparam int MODE_LSB = 5;

  // Bits per byte on the bus
  localparam logic [3:0] BYTE_BITS    = 4'h8;
  localparam logic [3:0] LAST_BIT     = 4'h7;

  // Resolution codes
  localparam logic [1:0] RES_16 = 2'h0;
  localparam logic [1:0] RES_12 = 2'h1;
  localparam logic [1:0] RES_8  = 2'h2;
  localparam logic [1:0] RES_4  = 2'h3;

  // Modulation code for the modulated LED setting; others drive DC
  localparam logic [1:0] MOD_360K = 2'h3;
  // Mode low bits that select proximity sensing
  localparam logic [1:0] PHASE_PROX = 2'h3;

  // LED modulation timing
  localparam int CLK_FREQ_KHZ    = 50000;
  localparam int MOD_FREQ_KHZ    = 360;
  localparam int MOD_HALF_CYCLES = CLK_FREQ_KHZ / (2 * MOD_FREQ_KHZ);
  localparam logic [7:0] MOD_HALF_LAST = 8'(MOD_HALF_CYCLES - 1);

  // Second command register layout
  typedef struct packed {
    logic [1:0] drive;
    logic [1:0] mod_freq;
    logic [1:0] res;
    logic [1:0] fsr;
  } lpr_cmd2_s;

  // Bus slave states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_ADDR  = 6'h02,
    ST_ACK   = 6'h04,
    ST_WDATA = 6'h08,
    ST_RDATA = 6'h10,
    ST_RACK  = 6'h20
  } lpr_state_e;

endpackage

// *** hdl/lpr_readout.sv ***
// Module: bus slave, conversion timing, result registers and LED gating
`timescale 1ns/1ps
module lpr_readout
  import lpr_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Serial bus pins, data is open-drain
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Analog front end
  input  wire logic       osc_tick,
  input  wire logic       adc_pulse,
  // LED driver and status
  output logic            ir_led_drive_output,
  output logic [1:0]      ir_drive_current,
  output logic            conv_busy
);

  // Highest count for a resolution code: 2^n - 1
  function automatic logic [15:0] res_limit(input logic [1:0] res);
    logic [15:0] lim;
    lim = 16'hffff;
    unique case (res)
      RES_16: lim = 16'hffff;
      RES_12: lim = 16'h0fff;
      RES_8:  lim = 16'h00ff;
      RES_4:  lim = 16'h000f;
    endcase
    return lim;
  endfunction

  // Byte returned for a register pointer
  function automatic logic [7:0] rd_byte(input logic [7:0] p, input logic [2:0] m,
                                         input lpr_cmd2_s c2, input logic [15:0] s);
    logic [7:0] b;
    b = 8'h00;
    unique case (p)
      REG_CMD1:   b = {m, 5'h00};
      REG_CMD2:   b = c2;
      REG_RES_LO: b = s[7:0];
      REG_RES_HI: b = s[15:8];
      default:    b = 8'h00;
    endcase
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  lpr_state_e  state;
  logic [3:0]  bitcnt;
  logic [7:0]  shreg;
  logic        rw;
  logic        first_byte;
  logic        host_ack;
  logic [7:0]  ptr;
  logic [2:0]  mode;
  lpr_cmd2_s   cmd2;
  logic [15:0] snap;
  logic        cmd_wr;
  logic        scl_q;
  logic        sda_q;
  logic [15:0] int_cnt;
  logic [15:0] acc;
  logic [15:0] result;
  logic [7:0]  mod_cnt;
  logic        mod_phase;

  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;
  logic [7:0]  next_ptr;
  logic [7:0]  next_byte;
  logic [7:0]  this_byte;
  logic [15:0] lim;
  logic [15:0] next_acc;

  ////////////////////////////////////////////////////////////////////////////
  // Bus event decode

  // Pins are synchronous, so one stage of history suffices for edges
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  // Edges and start/stop conditions
  assign scl_rise  = scl_in & ~scl_q;
  assign scl_fall  = ~scl_in & scl_q;
  assign start_c   = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_c    = scl_in & scl_q & ~sda_q & sda_in;
  assign next_ptr  = ptr + 8'h01;
  assign next_byte = rd_byte(next_ptr, mode, cmd2, snap);
  assign this_byte = rd_byte(ptr, mode, cmd2, snap);

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave and command registers

  // Open-drain: only ever pull low, so the data value is fixed at zero
  always_ff @(posedge clk) begin
    sda_out <= 1'b0;
  end

  // Slave sequencer; start and stop override any state
  always_ff @(posedge clk) begin
    if (rst) begin
      state      <= ST_IDLE;
      bitcnt     <= 4'h0;
      shreg      <= 8'h00;
      rw         <= 1'b0;
      first_byte <= 1'b0;
      host_ack   <= 1'b0;
      ptr        <= 8'h00;
      mode       <= MODE_RESET;
      cmd2       <= CMD2_RESET;
      snap       <= RESULT_RESET;
      cmd_wr     <= 1'b0;
      sda_oe     <= 1'b0;
    end else begin
      cmd_wr <= 1'b0;
      if (start_c) begin
        state  <= ST_ADDR;
        bitcnt <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop_c) begin
        state  <= ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        unique case (state)
          ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          ST_ADDR: begin
            if (scl_rise) begin
              shreg  <= {shreg[6:0], sda_in};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == BYTE_BITS) begin
              if (shreg[7:1] == I2C_ADDR) begin
                state      <= ST_ACK;
                sda_oe     <= 1'b1;
                rw         <= shreg[0];
                first_byte <= 1'b1;
                // Freeze the result for the whole read transfer
                if (shreg[0]) begin
                  snap <= result;
                end
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              bitcnt <= 4'h0;
              if (rw) begin
                shreg  <= this_byte;
                sda_oe <= ~this_byte[7];
                state  <= ST_RDATA;
              end else begin
                sda_oe <= 1'b0;
                state  <= ST_WDATA;
              end
            end
          end
          ST_WDATA: begin
            if (scl_rise) begin
              shreg  <= {shreg[6:0], sda_in};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == BYTE_BITS) begin
              sda_oe     <= 1'b1;
              state      <= ST_ACK;
              first_byte <= 1'b0;
              if (first_byte) begin
                ptr <= shreg;
              end else begin
                ptr <= next_ptr;
                // Result bytes are read-only; writes there are dropped
                if (ptr == REG_CMD1) begin
                  mode   <= shreg[MODE_MSB:MODE_LSB];
                  cmd_wr <= 1'b1;
                end else if (ptr == REG_CMD2) begin
                  cmd2   <= lpr_cmd2_s'(shreg);
                  cmd_wr <= 1'b1;
                end
              end
            end
          end
          ST_RDATA: begin
            if (scl_fall) begin
              if (bitcnt == LAST_BIT) begin
                sda_oe <= 1'b0;
                state  <= ST_RACK;
              end else begin
                shreg  <= {shreg[6:0], 1'b0};
                sda_oe <= ~shreg[6];
                bitcnt <= bitcnt + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              host_ack <= ~sda_in;
            end else if (scl_fall) begin
              ptr <= next_ptr;
              if (host_ack) begin
                shreg  <= next_byte;
                sda_oe <= ~next_byte[7];
                bitcnt <= 4'h0;
                state  <= ST_RDATA;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          default: begin
            state  <= ST_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion timing and result

  // Count saturates at 2^n - 1, so bits above n stay zero
  assign lim      = res_limit(cmd2.res);
  assign next_acc = (adc_pulse && acc < lim) ? acc + 16'h0001 : acc;

  // A command write restarts the conversion and wins over a completion
  always_ff @(posedge clk) begin
    if (rst) begin
      conv_busy <= 1'b0;
      int_cnt   <= 16'h0000;
      acc       <= 16'h0000;
      result    <= RESULT_RESET;
    end else if (cmd_wr) begin
      conv_busy <= (mode[1:0] != 2'h0);
      int_cnt   <= 16'h0000;
      acc       <= 16'h0000;
    end else if (conv_busy && osc_tick) begin
      // >= guards against a limit that shrank mid-conversion
      if (int_cnt >= lim) begin
        result  <= next_acc;
        int_cnt <= 16'h0000;
        acc     <= 16'h0000;
        if (!mode[2]) begin
          conv_busy <= 1'b0;
        end
      end else begin
        int_cnt <= int_cnt + 16'h0001;
        acc     <= next_acc;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // IR LED drive

  // Modulation square wave; unsupported codes fall back to DC
  always_ff @(posedge clk) begin
    if (rst) begin
      mod_cnt   <= 8'h00;
      mod_phase <= 1'b1;
    end else if (cmd2.mod_freq != MOD_360K) begin
      mod_cnt   <= 8'h00;
      mod_phase <= 1'b1;
    end else if (mod_cnt == MOD_HALF_LAST) begin
      mod_cnt   <= 8'h00;
      mod_phase <= ~mod_phase;
    end else begin
      mod_cnt   <= mod_cnt + 8'h01;
    end
  end

  // LED only while a proximity conversion runs
  always_ff @(posedge clk) begin
    if (rst) begin
      ir_led_drive_output <= 1'b0;
      ir_drive_current    <= 2'h0;
    end else begin
      ir_led_drive_output <= conv_busy && (mode[1:0] == PHASE_PROX) && mod_phase;
      ir_drive_current    <= cmd2.drive;
    end
  end

endmodule // lpr_readout

// *** dv/lpr_readout_sva.sv ***
// Checker: port properties of the result readout
`timescale 1ns/1ps
module lpr_readout_sva
  import lpr_pkg::*;
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Watched ports
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       osc_tick,
  input wire logic       adc_pulse,
  input wire logic       ir_led_drive_output,
  input wire logic [1:0] ir_drive_current,
  input wire logic       conv_busy
);
  logic [16:0] n_tk;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // Ticks of the running conversion; a restart mid-run would fool it, so the bench avoids one
  always_ff @(posedge clk) begin
    if (rst || !conv_busy) n_tk <= 17'h0;
    else if (osc_tick) n_tk <= n_tk + 17'h1;
  end
  // Bus, conversion and LED relations
  a_oe_on_low: assert property ($changed(sda_oe) |-> !$past(scl_in))
    else $error("sda moved with scl high");
  a_oe_stands: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("sda unstable in scl high");
  a_sda_zero: assert property (sda_out == 1'b0)
    else $error("sda driven high");
  a_len_pow2: assert property ($fell(conv_busy) && $past(osc_tick) |->
    n_tk inside {17'h10, 17'h100, 17'h1000, 17'h10000}) else $error("bad length");
  a_busy_min: assert property ($rose(conv_busy) |-> conv_busy [*8])
    else $error("conversion cut short");
  a_led_busy: assert property (ir_led_drive_output |-> $past(conv_busy))
    else $error("led on while idle");
  a_led_end: assert property ($fell(conv_busy) |=> !ir_led_drive_output [*3])
    else $error("led left on");
  a_reset_idle: assert property ($fell(rst) |-> !sda_oe && !conv_busy &&
    !ir_led_drive_output && ir_drive_current == 2'h0) else $error("not idle after reset");
  c_done: cover property ($fell(conv_busy));
  c_led: cover property ($rose(ir_led_drive_output));
  c_ack: cover property ($rose(sda_oe));
endmodule // lpr_readout_sva

bind lpr_readout lpr_readout_sva u_sva (.clk(clk), .rst(rst), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .osc_tick(osc_tick),
  .adc_pulse(adc_pulse), .ir_led_drive_output(ir_led_drive_output),
  .ir_drive_current(ir_drive_current), .conv_busy(conv_busy));

// *** dv/lpr_host_model.sv ***
// Partner: bus master model for the readout's serial port
`timescale 1ns/1ps
module lpr_host_model
  import lpr_pkg::*;
(
  // Clock and resolved data wire
  input wire logic clk,
  input wire logic sda,
  // Master lines; a released data line floats to the pull-up
  output logic     scl = 1'b1,
  output logic     sda_low = 1'b0
);
  int q = 4; // Clocks per third of a bit; raise it for a slow master
  ////////////////////////////////////////
  task automatic gap(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Start, repeated start or stop: data moves while the clock is high
  task automatic frame(input logic a, input logic b, input logic c);
    sda_low <= a;
    gap(q);
    scl <= 1'b1;
    gap(q);
    sda_low <= b;
    gap(q);
    scl <= c;
    gap(q);
  endtask
  // One bit: set while clock low, sampled at the end of clock high
  task automatic xbit(input logic b, output logic r);
    sda_low <= !b;
    gap(q);
    scl <= 1'b1;
    gap(q);
    r = sda;
    scl <= 1'b0;
    gap(q);
  endtask
  // Byte then acknowledge; nak releases the line in the ninth bit
  task automatic xbyte(input logic [7:0] d, input logic nak, output logic [7:0] r,
                       output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) xbit(d[i], r[i]);
    xbit(nak, a);
    ack = !a;
  endtask
  // Pointer write, then one data byte or a two-byte read in a single transfer
  task automatic xfer(input logic [6:0] a, input logic [7:0] p, input logic rdn,
                      input logic [7:0] d, output logic [15:0] v, output logic ok);
    logic [7:0] r;
    logic [3:0] k;
    frame(1'b0, 1'b1, 1'b0);
    xbyte({a, 1'b0}, 1'b1, r, k[0]);
    xbyte(p, 1'b1, r, k[1]);
    if (rdn) begin
      frame(1'b0, 1'b1, 1'b0);
      xbyte({a, 1'b1}, 1'b1, r, k[2]);
      xbyte(8'hff, 1'b0, v[7:0], k[3]);
      xbyte(8'hff, 1'b1, v[15:8], k[3]);
    end else xbyte(d, 1'b1, r, k[2]);
    frame(1'b1, 1'b0, 1'b1);
    ok = &k[2:0];
  endtask
endmodule // lpr_host_model

// *** dv/lpr_readout_bench.sv ***
// Testbench: readout driven over its serial bus by the master model
`timescale 1ns/1ps
module lpr_readout_bench;
  import lpr_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        osc_tick = 1'b0;
  logic        adc_pulse = 1'b0;
  logic        osc_en = 1'b1;
  logic        sat = 1'b0;
  logic [15:0] v;
  logic        ok;
  int          led_n = 0;
  int          n_errors = 0;
  int          compares = 0;
  wire         scl, sda_low, sda_out, sda_oe, led, busy;
  wire   [1:0] cur;
  wire         sda = !(sda_low || (sda_oe && !sda_out)); // Open drain, pulled up

  lpr_readout DUT (.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .osc_tick(osc_tick), .adc_pulse(adc_pulse),
    .ir_led_drive_output(led), .ir_drive_current(cur), .conv_busy(busy));
  lpr_host_model h (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  ////////////////////////////////////////
  always #10 clk = !clk;
  // Tick every clock while osc_en is set; pulses on alternate ticks give exactly half of 2^n
  always @(posedge clk) begin
    osc_tick <= osc_en;
    adc_pulse <= sat || !adc_pulse;
    led_n <= led_n + int'(led);
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wait_idle(input int lim);
    for (int i = 0; i < lim && busy !== 1'b0; i++) @(posedge clk);
    if (busy !== 1'b0) begin
      n_errors++;
      stop_test();
    end
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    h.xfer(I2C_ADDR, p, 1'b0, d, v, ok);
  endtask
  task automatic rd(input logic [7:0] p);
    h.xfer(I2C_ADDR, p, 1'b1, 8'h00, v, ok);
  endtask
  // Power down first, so no conversion is restarted while it runs
  task automatic run(input logic [2:0] md, input logic [7:0] c2);
    wr(REG_CMD1, 8'h00);
    wr(REG_CMD2, c2);
    wr(REG_CMD1, {md, 5'h00});
    chk(16'(ok), 16'h1);
    chk(16'(cur), 16'(c2[7:6]));
  endtask
  // One conversion: right-aligned count, LED only when proximity, result kept
  task automatic t_once(input logic [2:0] md, input logic [1:0] rs);
    int l0;
    logic [15:0] e;
    e = (sat ? 16'hffff : 16'h8000) >> (4 * rs);
    l0 = led_n;
    run(md, {rs, ((rs == RES_4) ? 2'h0 : MOD_360K), rs, 2'h1});
    wait_idle(70000);
    chk(16'(led_n > l0), 16'(md[1:0] == PHASE_PROX));
    rd(REG_RES_LO);
    chk(v, e);
    rd(REG_RES_LO);
    chk(v, e);
  endtask
  // Continuous mode refreshes; ticks stop before power-down ends it
  task automatic t_cont();
    run(3'h5, {4'h0, RES_4, 2'h0});
    repeat (200) @(posedge clk);
    chk(16'(busy), 16'h1);
    rd(REG_RES_LO);
    chk(v, 16'h0008);
    sat <= 1'b1;
    repeat (100) @(posedge clk);
    rd(REG_RES_LO);
    chk(v, 16'h000f);
    osc_en <= 1'b0;
    wr(REG_CMD1, 8'h00);
    wait_idle(100);
    osc_en <= 1'b1;
  endtask
  // Foreign address ignored, result read-only, space above it reads zero
  task automatic t_bad();
    h.xfer(I2C_ADDR ^ 7'h01, REG_CMD1, 1'b0, 8'h60, v, ok);
    chk(16'(ok), 16'h0);
    wr(REG_RES_HI, 8'h5a);
    rd(REG_RES_LO);
    chk(v, 16'h000f);
    chk(16'(busy), 16'h0);
    rd(8'h04);
    chk(v, 16'h0000);
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(REG_RES_LO);
    chk(v, RESULT_RESET);
    t_once(3'h1, RES_8);
    for (int r = 3; r >= 0; r--) t_once(3'h3, 2'(r));
    t_once(3'h2, RES_4);
    t_cont();
    h.q = 12;
    t_once(3'h3, RES_4);
    h.q = 4;
    t_bad();
    stop_test();
  end
endmodule // lpr_readout_bench
